//--- verilog/wdt_pkg.sv
package wdt_pkg;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_STATUS_IDX = 4'h0;
   localparam int POWER_ON_BIT = 7;
   localparam int UNDEF_BIT = 6;
   localparam int WATCHDOG_BIT = 5;
   localparam int EXTERNAL_BIT = 4;
   localparam int SOFTWARE_BIT = 3;
   localparam int ARM_CLEAR_BIT = 2;
   localparam int SEL_HI_BIT = 1;
   localparam int SEL_LO_BIT = 0;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
   localparam logic [CNT_W-1:0] CNT_TOP = 2'h3;
   localparam int SEL_W = 2;
   localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
   localparam int N_CARRY = 4;
   // Nominal interval exponents in oscillator cycles, per selection code
   localparam int INTERVAL_EXP_0 = 14;
   localparam int INTERVAL_EXP_1 = 16;
   localparam int INTERVAL_EXP_2 = 18;
   localparam int INTERVAL_EXP_3 = 21;
   localparam int N_SRC = 3;
   localparam int SRC_WATCHDOG = 0;
   localparam int SRC_EXTERNAL = 1;
   localparam int SRC_SOFTWARE = 2;
   localparam logic [N_SRC-1:0] SRC_NONE = 3'h0;
endpackage

//--- verilog/wdt_ctrl_if.sv
`timescale 1ns/1ns
interface wdt_ctrl_if;
   import wdt_pkg::*;
   logic armed;
   logic clear;
   logic halt;
   logic [SEL_W-1:0] sel;
   logic overflow;
   modport ctl (output armed, output clear, output halt, output sel, input overflow);
   modport cnt (input armed, input clear, input halt, input sel, output overflow);
endinterface

//--- verilog/wdt_counter.sv
`timescale 1ns/1ns
module wdt_counter #(
   parameter int NCARRY = wdt_pkg::N_CARRY
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [NCARRY-1:0] i_tb_carry,
   wdt_ctrl_if.cnt ctrl
);
   import wdt_pkg::*;
   logic [CNT_W-1:0] count_reg;
   logic tick;
   logic overflow_reg;

   assign tick = ctrl.armed & ~ctrl.halt & i_tb_carry[ctrl.sel];
   assign ctrl.overflow = overflow_reg;

   // Clear beats a same-cycle carry, so a timely clear never overflows
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         count_reg <= CNT_ZERO;
      end else if (ctrl.clear | ctrl.halt | ~ctrl.armed) begin
         count_reg <= CNT_ZERO;
      end else if (tick) begin
         count_reg <= (count_reg == CNT_TOP) ? CNT_ZERO : count_reg + CNT_ONE;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         overflow_reg <= 1'b0;
      end else begin
         overflow_reg <= ~ctrl.clear & tick & (count_reg == CNT_TOP);
      end
   end
endmodule

//--- verilog/wdt_cause_flags.sv
`timescale 1ns/1ns
module wdt_cause_flags (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [wdt_pkg::N_SRC-1:0] i_set,
   input wire logic i_clear,
   output logic o_power_on,
   output logic [wdt_pkg::N_SRC-1:0] o_src
);
   import wdt_pkg::*;
   logic power_on_reg;
   logic [N_SRC-1:0] src_reg;

   // Power-on flag is only ever set by the power-on reset itself
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         power_on_reg <= 1'b1;
      end else if (i_clear) begin
         power_on_reg <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_SRC; g++) begin : g_flag
         // Set wins over the read clear so no cause is lost
         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               src_reg[g] <= 1'b0;
            end else if (i_set[g]) begin
               src_reg[g] <= 1'b1;
            end else if (i_clear) begin
               src_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign o_power_on = power_on_reg;
   assign o_src = src_reg;
endmodule

//--- verilog/watchdog_reset_timer.sv
`timescale 1ns/1ns
module watchdog_reset_timer (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [wdt_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [wdt_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [wdt_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [wdt_pkg::N_CARRY-1:0] i_tb_carry,
   input wire logic i_ext_rst,
   input wire logic i_int_rst,
   input wire logic i_sw_rst,
   input wire logic i_sleep_enter,
   input wire logic i_tbt_mode,
   output logic o_wdt_rst,
   output logic o_armed
);
   import wdt_pkg::*;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
      reg_hit = (addr == CTRL_STATUS_IDX);
   endfunction

   wdt_ctrl_if ctrl ();

   logic ack_reg;
   logic take_rd;
   logic take_wr;
   logic zero_write;
   logic armed_reg;
   logic [SEL_W-1:0] sel_reg;
   logic wdt_rst_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic power_on;
   logic [N_SRC-1:0] src_flags;
   logic [N_SRC-1:0] src_set;

   // One wait cycle: request is taken at the first edge, released at the second
   assign take_rd = i_avs_read & ~ack_reg;
   assign take_wr = i_avs_write & ~ack_reg;
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take_rd | take_wr;
      end
   end

   // Writes of one to bit 2 fall out here and do nothing
   assign zero_write = take_wr & reg_hit(i_avs_address) & i_avs_byteenable[0]
      & ~i_avs_writedata[ARM_CLEAR_BIT];

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         armed_reg <= 1'b0;
      end else if (wdt_rst_reg) begin
         armed_reg <= 1'b0;
      end else if (zero_write) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         sel_reg <= SEL_RESET;
      end else if (zero_write & ~armed_reg) begin
         sel_reg <= i_avs_writedata[SEL_HI_BIT:SEL_LO_BIT];
      end
   end

   assign ctrl.armed = armed_reg;
   assign ctrl.sel = sel_reg;
   assign ctrl.halt = i_tbt_mode;
   assign ctrl.clear = (zero_write & armed_reg) | i_ext_rst | i_int_rst | i_sw_rst
      | i_sleep_enter;

   wdt_counter #(
      .NCARRY(N_CARRY)
   ) u_counter (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_tb_carry(i_tb_carry),
      .ctrl(ctrl)
   );

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wdt_rst_reg <= 1'b0;
      end else begin
         wdt_rst_reg <= ctrl.overflow & armed_reg;
      end
   end

   assign src_set[SRC_WATCHDOG] = wdt_rst_reg;
   assign src_set[SRC_EXTERNAL] = i_ext_rst;
   assign src_set[SRC_SOFTWARE] = i_sw_rst;

   wdt_cause_flags u_flags (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_set(src_set),
      .i_clear(take_rd & reg_hit(i_avs_address)),
      .o_power_on(power_on),
      .o_src(src_flags)
   );

   // Bit 6 and the write-only bits read as zero; upper bits zero
   always_comb begin
      rdata_next = '0;
      if (reg_hit(i_avs_address)) begin
         rdata_next[POWER_ON_BIT] = power_on;
         rdata_next[WATCHDOG_BIT] = src_flags[SRC_WATCHDOG];
         rdata_next[EXTERNAL_BIT] = src_flags[SRC_EXTERNAL];
         rdata_next[SOFTWARE_BIT] = src_flags[SRC_SOFTWARE];
         rdata_next[UNDEF_BIT] = 1'b0;
         rdata_next[SEL_HI_BIT] = 1'b0;
         rdata_next[SEL_LO_BIT] = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdata_reg <= '0;
      end else if (take_rd) begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_avs_readdata = rdata_reg;
   assign o_wdt_rst = wdt_rst_reg;
   assign o_armed = armed_reg;
endmodule

//--- sim/watchdog_reset_timer_sva.sv
`timescale 1ns/1ns
module wdt_checker
   import wdt_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [DATA_W-1:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [N_CARRY-1:0] i_tb_carry,
   input wire logic i_ext_rst,
   input wire logic i_int_rst,
   input wire logic i_sw_rst,
   input wire logic i_sleep_enter,
   input wire logic i_tbt_mode,
   input wire logic o_wdt_rst,
   input wire logic o_armed
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   wire done = !o_avs_waitrequest && i_avs_address == CTRL_STATUS_IDX;
   sequence s_fire;
      o_wdt_rst ##1 !o_wdt_rst && !o_armed;
   endsequence
   fire_drop_a: assert property (o_wdt_rst |-> s_fire)
      else $error("reset pulse without disarm");
   armed_fire_a: assert property (o_wdt_rst |-> $past(o_armed) && $past(i_tb_carry, 2) != '0)
      else $error("reset pulse without armed carry");
   fell_cause_a: assert property ($fell(o_armed) |-> $past(o_wdt_rst))
      else $error("disarm without reset pulse");
   arm_write_a: assert property (done && i_avs_write && i_avs_byteenable[0]
      && !i_avs_writedata[ARM_CLEAR_BIT] |-> o_armed)
      else $error("zero write left block unarmed");
   one_write_a: assert property (done && i_avs_write
      && i_avs_writedata[ARM_CLEAR_BIT] && !$past(o_armed) |-> !o_armed)
      else $error("one write armed the block");
   rd_mask_a: assert property (done && i_avs_read
      |-> (o_avs_readdata & 32'hffffff47) == 32'h0)
      else $error("reserved read bits set");
   // Two cycles on: a carry taken just before the clear may still fire next cycle
   clr_nofire_a: assert property ((i_ext_rst || i_int_rst || i_sw_rst || i_sleep_enter)
      |-> ##2 !o_wdt_rst)
      else $error("reset pulse after clear");
   tbt_hold_a: assert property (i_tbt_mode [*3] |-> !o_wdt_rst)
      else $error("reset pulse in timebase mode");
endmodule
bind watchdog_reset_timer wdt_checker wdt_checker_i (.*);

//--- sim/watchdog_reset_timer_tb_top.sv
`timescale 1ns/1ns
module watchdog_reset_timer_tb_top;
   import wdt_pkg::*;
   logic clk = 0, rst = 1, rd = 0, wr = 0, tbt = 0;
   logic [3:0] evs = '0;
   logic [3:0] be = 4'hf;
   logic [N_CARRY-1:0] car = '0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wd = '0, rdo, rdata;
   logic wait_req, fire, armed;
   int errors = 0, checked = 0, fires = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (fire === 1'b1) fires <= fires + 1;
   watchdog_reset_timer watchdog_reset_timer_i (
      .i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .o_avs_readdata(rdo), .o_avs_waitrequest(wait_req), .i_tb_carry(car),
      .i_ext_rst(evs[0]), .i_int_rst(evs[1]), .i_sw_rst(evs[2]), .i_sleep_enter(evs[3]),
      .i_tbt_mode(tbt), .o_wdt_rst(fire), .o_armed(armed));
   task end_sim;
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task bus(input logic w, input logic [7:0] d, input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0);
      rdata = rdo;
      rd <= 0;
      wr <= 0;
      chk("access edges", 2, n);
   endtask
   task pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk);
         car <= 4'h1 << idx;
         @(posedge clk);
         car <= '0;
      end
   endtask
   task ev(input int k);
      @(posedge clk);
      evs[k] <= 1;
      @(posedge clk);
      evs[k] <= 0;
   endtask
   // Pulse lands one edge late, the counter one more
   task settle;
      repeat (3) @(posedge clk);
   endtask
   task t_reset;
      bus(0, 8'h0, 4'h0);
      chk("flags", 32'h80, rdata);
      bus(0, 8'h0, 4'h0);
      chk("flags", 32'h0, rdata);
      bus(0, 8'h0, 4'h1);
      chk("unmapped", 32'h0, rdata);
   endtask
   task t_arm;
      bus(1, 8'h04, 4'h0);
      bus(1, 8'h00, 4'h1);
      be <= 4'he;
      bus(1, 8'h00, 4'h0);
      be <= 4'hf;
      for (int k = 0; k < N_CARRY; k++) pulse(k, 4);
      settle;
      chk("armed", 0, armed);
      chk("fires", 0, fires);
      bus(1, 8'h41, 4'h0);
      chk("armed", 1, armed);
   endtask
   task t_clear;
      pulse(1, 3);
      bus(1, 8'h00, 4'h0);
      pulse(0, 4);
      pulse(1, 3);
      for (int k = 0; k < 4; k++) begin
         ev(k);
         pulse(1, 3);
      end
      @(posedge clk);
      tbt <= 1;
      pulse(1, 4);
      tbt <= 0;
      pulse(1, 3);
      settle;
      chk("fires", 0, fires);
      chk("armed", 1, armed);
      pulse(1, 1);
      settle;
      chk("fires", 1, fires);
      chk("armed", 0, armed);
      bus(0, 8'h0, 4'h0);
      chk("flags", 32'h38, rdata);
   endtask
   task t_sel;
      for (int n = 0; n < 4; n++) begin
         bus(1, 8'(n), 4'h0);
         pulse((n + 1) % 4, 4);
         pulse(n, 3);
         settle;
         chk("fires", 1 + n, fires);
         pulse(n, 1);
         settle;
         chk("fires", 2 + n, fires);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      t_reset;
      t_arm;
      t_clear;
      t_sel;
      end_sim;
   end
   initial begin
      #100000;
      errors++;
      end_sim;
   end
endmodule
